// *** inc/kpcf_defines.svh ***
// Offsets, field positions and reset values of the keypad port block.
// Assumes 7-bit nibble addresses shared by data memory and register file.
`ifndef KPCF_DEFINES_SVH
`define KPCF_DEFINES_SVH

// ****************************************************************
// Data memory port registers
// ****************************************************************
`define KPCF_DM_BIDIR     7'h6f
`define KPCF_DM_KEY_A     7'h70
`define KPCF_DM_KEY_B     7'h71
`define KPCF_DM_DRIVE_C   7'h72
`define KPCF_DM_DRIVE_D   7'h73

// ****************************************************************
// Register file control nibbles
// ****************************************************************
`define KPCF_RF_INT_LEVEL 7'h0f
`define KPCF_RF_PULLUP    7'h17
`define KPCF_RF_EDGE_SEL  7'h1f
`define KPCF_RF_DIRECTION 7'h27
`define KPCF_RF_INT_REQ   7'h3e
`define KPCF_RF_MEM_BASE  7'h40

// ****************************************************************
// Field positions
// ****************************************************************
`define KPCF_INT_LEVEL_BIT 0
`define KPCF_INT_REQ_BIT   0
`define KPCF_EDGE_SEL_BIT  0

// ****************************************************************
// Reset values
// ****************************************************************
`define KPCF_PULLUP_RST   4'hf
`define KPCF_DIR_RST      4'h0
`define KPCF_DRIVE_RST    4'h0
`define KPCF_BIDIR_RST    4'h0
`define KPCF_EDGE_RST     1'b0
`define KPCF_SYNC_RST     13'h1fff

`endif

// *** inc/kpcf_pkg.sv ***
// Types shared by the keypad port block modules.
// Assumes nothing beyond a SystemVerilog compiler.
package kpcf_pkg;

  typedef logic [3:0] kpcf_nib_type;

  typedef enum {
    PORT_NONE, PORT_BIDIR, PORT_KEY_A, PORT_KEY_B, PORT_DRIVE_C, PORT_DRIVE_D
  } kpcf_port_type;

  typedef enum {
    RF_UNUSED, RF_INT_LEVEL, RF_PULLUP, RF_EDGE_SEL, RF_DIRECTION, RF_INT_REQ,
    RF_MEM
  } kpcf_rf_type;

endpackage

// *** inc/kpcf_int_if.sv ***
// Link between the port top and the external interrupt detector.
// Assumes the level is already synchronised to sys_clk.
`timescale 1ns/1ps
`default_nettype none

interface kpcf_int_if;
  logic level;
  logic edge_sel;
  logic irq_wr;
  logic irq_wval;
  logic irq;

  modport det (input level, edge_sel, irq_wr, irq_wval, output irq);
  modport ctl (output level, edge_sel, irq_wr, irq_wval, input irq);
endinterface

`default_nettype wire

// *** logic/kpcf_sync.sv ***
// Two-stage synchroniser for the pin inputs.
// Assumes the pins may change at any time relative to sys_clk.
`timescale 1ns/1ps
`default_nettype none

module kpcf_sync #(
  parameter int               WIDTH   = 13,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= RST_VAL;
      dout     <= RST_VAL;
    end
    else
    begin
      meta_reg <= din;  // RQ20
      dout     <= meta_reg;
    end
  end

  property p_two_stage;
    @(posedge sys_clk) disable iff (rst) !$past(rst, 2) |-> dout == $past(din, 2);
  endproperty
  a_two_stage: assert property (p_two_stage) else $error("sync delay not two"); // RQ20

endmodule // kpcf_sync

`default_nettype wire

// *** logic/kpcf_int_det.sv ***
// External interrupt edge detector and sticky request flag.
// Assumes a synchronised level arrives through the interface.
`timescale 1ns/1ps
`default_nettype none

module kpcf_int_det
  import kpcf_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Detector side of the link
  kpcf_int_if.det   bus
);

  logic prev_reg;
  logic primed_reg;
  logic irq_reg;
  logic hit;

  // No edge on the first cycle: the pin level at release is unknown
  assign hit = primed_reg &&
               (bus.edge_sel ? (prev_reg && !bus.level) : (!prev_reg && bus.level));

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      prev_reg   <= 1'b0;
      primed_reg <= 1'b0;
    end
    else
    begin
      prev_reg   <= bus.level;
      primed_reg <= 1'b1;
    end
  end

  // Edge wins over a software write in the same cycle
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      irq_reg <= 1'b0;
    else if (hit)
      irq_reg <= 1'b1;  // RQ13
    else if (bus.irq_wr)
      irq_reg <= bus.irq_wval;
  end

  assign bus.irq = irq_reg;

  property p_edge_sets;
    @(posedge sys_clk) disable iff (rst) hit |=> irq_reg;
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("edge lost"); // RQ13

  property p_rise_only;
    @(posedge sys_clk) disable iff (rst)
      (primed_reg && !bus.edge_sel && $rose(bus.level) && !irq_reg && !bus.irq_wr) |=> irq_reg;
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("rising edge missed"); // RQ13

  c_irq_set: cover property (@(posedge sys_clk) disable iff (rst) $rose(irq_reg));

endmodule // kpcf_int_det

`default_nettype wire

// *** logic/kpcf_top.sv ***
// Keypad port block: key input ports, open-drain drive ports, a bit I/O
// port, external interrupt pin and the control register file nibbles.
// Assumes the core issues at most one access per path per cycle.
//
// What this block does
// RQ1: Reading data address 70H returns live pins of key input port A.
// RQ2: Reading data address 71H returns live pins of key input port B.
// RQ3: In standby, a low on any key input pin releases standby.
// RQ4: Address 72H is a 4-bit open-drain latch; reads return the latch.
// RQ5: Address 73H behaves the same as 72H for the second drive port.
// RQ6: In standby both drive ports pull all pins low.
// RQ7: Direction nibble at 27H sets each bit I/O pin as input or output.
// RQ8: Address 6F reads pins for inputs, latch for outputs; writes load latch.
// RQ9: Pull-up nibble at 17H connects each bit I/O pull-up.
// RQ10: Output mode keeps the pull-up; only clearing its bit removes it.
// RQ11: After reset every bit I/O pin is an input.
// RQ12: Switching a pin to output drives the latch value at once.
// RQ13: Selected edge on the interrupt pin sets the request flag, 3EH bit 0.
// RQ14: Nibble 0FH bit 0 shows the interrupt pin level.
// RQ15: File addresses 00H-3FH are control nibbles; 40H-7FH are data memory.
// RQ16: Control_file_read copies a file nibble to the window; control_file_write copies it back.
// RQ17: Unused control nibbles read undefined and ignore writes.
// RQ18: Writes to read-only nibbles change nothing.
// RQ19: Upper bank ignores writes to 70H-73H and reads lower bank ports.
// RQ20: Interrupt and input pins pass two flip-flops before use.
// RQ21: Reset clears both drive latches and sets the pull-up enables.
`timescale 1ns/1ps
`default_nettype none
`include "kpcf_defines.svh"

module kpcf_top
  import kpcf_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Data memory access
  input  wire logic [6:0] dm_addr,
  input  wire logic       dm_rd,
  input  wire logic       dm_wr,
  input  wire logic [3:0] dm_wdata,
  input  wire logic       upper_memory_bank,
  output logic      [3:0] dm_rdata,
  output logic            dm_rvalid,
  // Register file access
  input  wire logic [6:0] rf_addr,
  input  wire logic       control_file_read,
  input  wire logic       control_file_write,
  input  wire logic [3:0] window_wdata,
  output logic      [3:0] window_rdata,
  output logic            window_rvalid,
  output logic            rf_mem_hit,
  // Standby
  input  wire logic       standby,
  output logic            standby_release,
  // Key pins
  input  wire logic [3:0] key_input_port_a_i,
  input  wire logic [3:0] key_input_port_b_i,
  output logic      [3:0] key_drive_port_c_o,
  output logic      [3:0] key_drive_port_c_oe,
  output logic      [3:0] key_drive_port_d_o,
  output logic      [3:0] key_drive_port_d_oe,
  // Bit I/O pins
  input  wire logic [3:0] bidir_port_i,
  output logic      [3:0] bidir_port_o,
  output logic      [3:0] bidir_port_oe,
  output logic      [3:0] bidir_pullup_on,
  // Interrupt pin
  input  wire logic       ext_int_i
);

  kpcf_nib_type  key_a_s;
  kpcf_nib_type  key_b_s;
  kpcf_nib_type  bidir_s;
  logic          ext_int_s;
  kpcf_nib_type  drive_c_reg;
  kpcf_nib_type  drive_d_reg;
  kpcf_nib_type  bidir_lat_reg;
  kpcf_nib_type  pullup_reg;
  kpcf_nib_type  dir_reg;
  logic          edge_sel_reg;
  kpcf_nib_type  drive_c_next;
  kpcf_nib_type  drive_d_next;
  kpcf_nib_type  bidir_lat_next;
  kpcf_port_type dm_rsel;
  kpcf_port_type dm_wsel;
  kpcf_port_type rf_port;
  kpcf_port_type rf_wsel;
  kpcf_rf_type   rf_sel;
  logic          rf_control_file_write;
  kpcf_nib_type  rf_rval;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  // Port registers 70H-73H are common to both banks on read
  function automatic kpcf_port_type port_decode(input logic [6:0] a, input logic up);
    case (a)
      `KPCF_DM_BIDIR:   return up ? PORT_NONE : PORT_BIDIR;
      `KPCF_DM_KEY_A:   return PORT_KEY_A;
      `KPCF_DM_KEY_B:   return PORT_KEY_B;
      `KPCF_DM_DRIVE_C: return PORT_DRIVE_C;
      `KPCF_DM_DRIVE_D: return PORT_DRIVE_D;
      default:          return PORT_NONE;
    endcase
  endfunction

  function automatic kpcf_rf_type rf_decode(input logic [6:0] a);
    if (a >= `KPCF_RF_MEM_BASE)
      return RF_MEM;  // RQ15
    case (a)
      `KPCF_RF_INT_LEVEL: return RF_INT_LEVEL;
      `KPCF_RF_PULLUP:    return RF_PULLUP;
      `KPCF_RF_EDGE_SEL:  return RF_EDGE_SEL;
      `KPCF_RF_DIRECTION: return RF_DIRECTION;
      `KPCF_RF_INT_REQ:   return RF_INT_REQ;
      default:            return RF_UNUSED;
    endcase
  endfunction

  function automatic kpcf_nib_type flag_nib(input logic f, input int pos);
    flag_nib = '0;
    flag_nib[pos] = f;
  endfunction

  // Pins for inputs, latch for outputs
  function automatic kpcf_nib_type port_read(input kpcf_port_type p);
    case (p)
      PORT_BIDIR:   return (dir_reg & bidir_lat_reg) | (~dir_reg & bidir_s);  // RQ8
      PORT_KEY_A:   return key_a_s;  // RQ1
      PORT_KEY_B:   return key_b_s;  // RQ2
      PORT_DRIVE_C: return drive_c_reg;  // RQ4
      PORT_DRIVE_D: return drive_d_reg;  // RQ5
      default:      return '0;
    endcase
  endfunction

  // Data memory write wins over a control_file_write to the same latch
  function automatic kpcf_nib_type wr_pick(input kpcf_port_type p, input kpcf_nib_type cur);
    if (dm_wsel == p)
      return dm_wdata;
    if (rf_wsel == p)
      return window_wdata;
    return cur;
  endfunction

  // ****************************************************************
  // Pin synchronisers and interrupt detector
  // ****************************************************************
  kpcf_sync #(
    .WIDTH   (13),
    .RST_VAL (`KPCF_SYNC_RST)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .din     ({ext_int_i, bidir_port_i, key_input_port_b_i, key_input_port_a_i}),
    .dout    ({ext_int_s, bidir_s, key_b_s, key_a_s})
  );

  kpcf_int_if int_bus ();

  assign int_bus.level    = ext_int_s;
  assign int_bus.edge_sel = edge_sel_reg;
  assign int_bus.irq_wr   = rf_control_file_write && (rf_sel == RF_INT_REQ);
  assign int_bus.irq_wval = window_wdata[`KPCF_INT_REQ_BIT];

  kpcf_int_det u_int_det (
    .sys_clk (sys_clk),
    .rst     (rst),
    .bus     (int_bus.det)
  );

  // ****************************************************************
  // Access decode
  // ****************************************************************
  assign rf_sel  = rf_decode(rf_addr);
  assign rf_control_file_write = control_file_write;
  assign rf_port = (rf_sel == RF_MEM) ? port_decode(rf_addr, upper_memory_bank) : PORT_NONE;
  assign dm_rsel = port_decode(dm_addr, upper_memory_bank);
  // Upper bank drops writes; key inputs A and B are read-only
  assign dm_wsel = (dm_wr && !upper_memory_bank &&  // RQ19
                    dm_rsel != PORT_KEY_A && dm_rsel != PORT_KEY_B) ? dm_rsel : PORT_NONE;  // RQ18
  assign rf_wsel = (rf_control_file_write && !upper_memory_bank &&  // RQ19
                    rf_port != PORT_KEY_A && rf_port != PORT_KEY_B) ? rf_port : PORT_NONE;  // RQ18

  // A process, so that the decode read inside wr_pick wakes it
  always_comb
  begin
    drive_c_next   = wr_pick(PORT_DRIVE_C, drive_c_reg);
    drive_d_next   = wr_pick(PORT_DRIVE_D, drive_d_reg);
    bidir_lat_next = wr_pick(PORT_BIDIR, bidir_lat_reg);  // RQ8
  end

  // Unused nibbles read as zero, a fixed stand-in for undefined
  always_comb
  begin
    case (rf_sel)
      RF_INT_LEVEL: rf_rval = flag_nib(ext_int_s, `KPCF_INT_LEVEL_BIT);  // RQ14
      RF_PULLUP:    rf_rval = pullup_reg;
      RF_EDGE_SEL:  rf_rval = flag_nib(edge_sel_reg, `KPCF_EDGE_SEL_BIT);
      RF_DIRECTION: rf_rval = dir_reg;
      RF_INT_REQ:   rf_rval = flag_nib(int_bus.irq, `KPCF_INT_REQ_BIT);
      RF_MEM:       rf_rval = port_read(rf_port);
      default:      rf_rval = '0;  // RQ17
    endcase
  end

  // ****************************************************************
  // Port latches
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      drive_c_reg   <= `KPCF_DRIVE_RST;  // RQ21
      drive_d_reg   <= `KPCF_DRIVE_RST;  // RQ21
      bidir_lat_reg <= `KPCF_BIDIR_RST;
    end
    else
    begin
      drive_c_reg   <= drive_c_next;  // RQ4
      drive_d_reg   <= drive_d_next;  // RQ5
      bidir_lat_reg <= bidir_lat_next;
    end
  end

  // ****************************************************************
  // Control nibbles
  // ****************************************************************
  // Level nibble and unused nibbles have no storage, so pokes fall away
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pullup_reg   <= `KPCF_PULLUP_RST;  // RQ21
      dir_reg      <= `KPCF_DIR_RST;  // RQ11
      edge_sel_reg <= `KPCF_EDGE_RST;
    end
    else if (rf_control_file_write)
    begin
      if (rf_sel == RF_PULLUP)
        pullup_reg <= window_wdata;  // RQ9
      if (rf_sel == RF_DIRECTION)
        dir_reg <= window_wdata;  // RQ7
      if (rf_sel == RF_EDGE_SEL)
        edge_sel_reg <= window_wdata[`KPCF_EDGE_SEL_BIT];
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  // Pull-up follows its own enable only, never the direction
  assign bidir_pullup_on = pullup_reg;  // RQ10
  assign bidir_port_oe   = dir_reg;  // RQ7
  assign bidir_port_o    = bidir_lat_reg;  // RQ12

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      key_drive_port_c_o  <= '0;
      key_drive_port_d_o  <= '0;
      key_drive_port_c_oe <= ~`KPCF_DRIVE_RST;
      key_drive_port_d_oe <= ~`KPCF_DRIVE_RST;
    end
    else
    begin
      key_drive_port_c_o  <= '0;
      key_drive_port_d_o  <= '0;
      key_drive_port_c_oe <= standby ? 4'hf : ~drive_c_next;  // RQ6
      key_drive_port_d_oe <= standby ? 4'hf : ~drive_d_next;  // RQ6
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      standby_release <= 1'b0;
    else
      standby_release <= standby && !(&key_a_s && &key_b_s);  // RQ3
  end

  // ****************************************************************
  // Read answers
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dm_rdata      <= '0;
      dm_rvalid     <= 1'b0;
      window_rdata  <= '0;
      window_rvalid <= 1'b0;
      rf_mem_hit    <= 1'b0;
    end
    else
    begin
      dm_rvalid     <= dm_rd;
      window_rvalid <= control_file_read;
      rf_mem_hit    <= (control_file_read || rf_control_file_write) &&
                       (rf_sel == RF_MEM) && (rf_port == PORT_NONE);  // RQ15
      if (dm_rd)
        dm_rdata <= port_read(dm_rsel);
      if (control_file_read)
        window_rdata <= rf_rval;  // RQ16
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_read_a; dm_rd && dm_addr == `KPCF_DM_KEY_A |=> dm_rvalid && dm_rdata == $past(key_a_s); endproperty
  a_read_a: assert property (p_read_a) else $error("port A read wrong"); // RQ1
  property p_read_b; dm_rd && dm_addr == `KPCF_DM_KEY_B |=> dm_rdata == $past(key_b_s); endproperty
  a_read_b: assert property (p_read_b) else $error("port B read wrong"); // RQ2
  property p_wake; standby && key_b_s != 4'hf |=> standby_release; endproperty
  a_wake: assert property (p_wake) else $error("standby not released"); // RQ3
  property p_c_back;
    dm_wr && !upper_memory_bank && dm_addr == `KPCF_DM_DRIVE_C ##1 !dm_wr && !rf_control_file_write
      ##1 dm_rd && dm_addr == `KPCF_DM_DRIVE_C && !dm_wr && !rf_control_file_write
      |=> dm_rdata == $past(dm_wdata, 3);
  endproperty
  a_c_back: assert property (p_c_back) else $error("port C latch readback wrong"); // RQ4
  property p_d_pins; !standby ##1 !standby |-> key_drive_port_d_oe == ~$past(drive_d_next); endproperty
  a_d_pins: assert property (p_d_pins) else $error("port D pins not from latch"); // RQ5
  property p_standby_low; standby |=> key_drive_port_c_oe == 4'hf && key_drive_port_d_oe == 4'hf; endproperty
  a_standby_low: assert property (p_standby_low) else $error("drive ports not low in standby"); // RQ6
  property p_dir; rf_control_file_write && rf_addr == `KPCF_RF_DIRECTION |=> bidir_port_oe == $past(window_wdata); endproperty
  a_dir: assert property (p_dir) else $error("direction not applied"); // RQ7
  property p_bidir_rd;
    dm_rd && dm_addr == `KPCF_DM_BIDIR && !upper_memory_bank
      |=> dm_rdata == $past((dir_reg & bidir_lat_reg) | (~dir_reg & bidir_s));
  endproperty
  a_bidir_rd: assert property (p_bidir_rd) else $error("bit I/O read wrong"); // RQ8
  property p_pullup; rf_control_file_write && rf_addr == `KPCF_RF_PULLUP |=> bidir_pullup_on == $past(window_wdata); endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up not applied"); // RQ9
  property p_pullup_hold; !(rf_control_file_write && rf_addr == `KPCF_RF_PULLUP) |=> $stable(bidir_pullup_on); endproperty
  a_pullup_hold: assert property (p_pullup_hold) else $error("pull-up changed by itself"); // RQ10
  property p_switch_out; $rose(bidir_port_oe[0]) |-> bidir_port_o[0] == bidir_lat_reg[0]; endproperty
  a_switch_out: assert property (p_switch_out) else $error("latch not driven on switch"); // RQ12
  property p_level; control_file_read && rf_addr == `KPCF_RF_INT_LEVEL |=> window_rdata[0] == $past(ext_int_s); endproperty
  a_level: assert property (p_level) else $error("interrupt level wrong"); // RQ14
  property p_mem; control_file_read && rf_addr >= `KPCF_RF_MEM_BASE && rf_port == PORT_NONE |=> rf_mem_hit; endproperty
  a_mem: assert property (p_mem) else $error("memory range not forwarded"); // RQ15
  property p_unused;
    rf_control_file_write && rf_sel == RF_UNUSED |=> $stable(pullup_reg) && $stable(dir_reg) && $stable(edge_sel_reg);
  endproperty
  a_unused: assert property (p_unused) else $error("unused nibble write took effect"); // RQ17
  property p_ro;
    dm_wr && (dm_addr == `KPCF_DM_KEY_A || dm_addr == `KPCF_DM_KEY_B) && !rf_control_file_write
      |=> $stable(drive_c_reg) && $stable(drive_d_reg) && $stable(bidir_lat_reg);
  endproperty
  a_ro: assert property (p_ro) else $error("read-only write took effect"); // RQ18
  property p_upper;
    dm_wr && upper_memory_bank && !rf_control_file_write |=> $stable(drive_c_reg) && $stable(drive_d_reg);
  endproperty
  a_upper: assert property (p_upper) else $error("upper bank write reached ports"); // RQ19
  property p_reset_vals; $fell(rst) |-> drive_c_reg == 4'h0 && pullup_reg == 4'hf && dir_reg == 4'h0; endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong"); // RQ21

  c_wake:    cover property (standby ##1 standby_release);
  c_bidir:   cover property (dm_rd && dm_rsel == PORT_BIDIR && dir_reg != 4'h0);
  c_upper:   cover property (dm_wr && upper_memory_bank && dm_rsel == PORT_DRIVE_C);
  c_rf_control_file_read: cover property (control_file_read && rf_sel == RF_INT_REQ);

endmodule // kpcf_top

`default_nettype wire

// *** bench/kpcf_pins_model.sv ***
// Key switches, bit I/O far side and interrupt source.
// Assumes the pins of kpcf_top; key inputs carry pull-ups.
`timescale 1ns/1ps
`default_nettype none

module kpcf_pins_model (
  // Clock
  input  wire logic       sys_clk,
  // Bench controls
  input  wire logic [3:0] press_a,
  input  wire logic [3:0] press_b,
  input  wire logic [3:0] ext_en,
  input  wire logic [3:0] ext_val,
  input  wire logic       int_lvl,
  // Device pins
  input  wire logic [3:0] pin_o,
  input  wire logic [3:0] pin_oe,
  input  wire logic [3:0] pull_on,
  output logic      [3:0] key_a,
  output logic      [3:0] key_b,
  output logic      [3:0] pin_i,
  output logic            int_o
);
  logic [3:0] last = 4'h0;

  // Pressed key pulls its line low
  assign key_a = ~press_a;
  assign key_b = ~press_b;
  assign int_o = int_lvl;

  // Floating bit reads high with its pull-up on; without it, the inverse of its last level, never a stale match
  always_comb
    for (int k = 0; k < 4; k++)
      pin_i[k] = pin_oe[k] ? pin_o[k] : ext_en[k] ? ext_val[k] : pull_on[k] | ~last[k];

  always_ff @(posedge sys_clk)
    last <= pin_i;
endmodule // kpcf_pins_model

`default_nettype wire

// *** bench/test_keypad_ports_and_control_file.sv ***
// Self-checking bench for the keypad port block.
// Assumes kpcf_top, its package and kpcf_pins_model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module test_keypad_ports_and_control_file;
  logic       sys_clk = 1'h0;
  logic       rst = 1'h1;
  logic [3:0] stb = 4'h0;
  logic [6:0] addr = 7'h00;
  logic [3:0] wdata = 4'h0, press_a = 4'h0, press_b = 4'h0, ext_en = 4'h0, ext_val = 4'h0;
  logic       bank = 1'h0, standby = 1'h0, int_lvl = 1'h0;
  logic [3:0] dm_rdata, window_rdata, c_o, c_oe, d_o, d_oe, b_o, b_oe, pull_on;
  logic [3:0] key_a, key_b, pin_i;
  logic       dm_rvalid, window_rvalid, rf_mem_hit, standby_release, int_o;
  int         num_errors = 0;
  int         n_compared = 0;

  kpcf_top u_dut (.sys_clk(sys_clk), .rst(rst), .dm_addr(addr), .dm_rd(stb[0]),
    .dm_wr(stb[1]), .dm_wdata(wdata), .upper_memory_bank(bank), .dm_rdata(dm_rdata),
    .dm_rvalid(dm_rvalid), .rf_addr(addr), .control_file_read(stb[2]),
    .control_file_write(stb[3]), .window_wdata(wdata), .window_rdata(window_rdata),
    .window_rvalid(window_rvalid), .rf_mem_hit(rf_mem_hit), .standby(standby),
    .standby_release(standby_release), .key_input_port_a_i(key_a),
    .key_input_port_b_i(key_b), .key_drive_port_c_o(c_o), .key_drive_port_c_oe(c_oe),
    .key_drive_port_d_o(d_o), .key_drive_port_d_oe(d_oe), .bidir_port_i(pin_i),
    .bidir_port_o(b_o), .bidir_port_oe(b_oe), .bidir_pullup_on(pull_on), .ext_int_i(int_o));

  kpcf_pins_model u_pins (.sys_clk(sys_clk), .press_a(press_a), .press_b(press_b),
    .ext_en(ext_en), .ext_val(ext_val), .int_lvl(int_lvl), .pin_o(b_o), .pin_oe(b_oe),
    .pull_on(pull_on), .key_a(key_a), .key_b(key_b), .pin_i(pin_i), .int_o(int_o));

  initial
    forever #2 sys_clk = ~sys_clk;

  // ********************
  // Access and check tasks
  // ********************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One strobe: dm read, dm write, control_file_read, control_file_write by {rf, wr}
  task automatic acc(input logic rf, input logic wr, input logic [6:0] a, input logic [3:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    stb <= 4'h1 << {rf, wr};
    @(posedge sys_clk);
    stb <= 4'h0;
    #1;
  endtask

  task automatic rd(input logic rf, input logic [6:0] a, input logic [3:0] e);
    acc(rf, 1'h0, a, 4'h0);
    chk(rf ? {window_rvalid, window_rdata} : {dm_rvalid, dm_rdata}, {1'h1, e});
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ********************
  // Tests
  // ********************
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'h0;
    #1;
    chk({c_oe, d_oe}, 8'hff);
    chk({b_oe, pull_on}, 8'h0f);
    rd(1'h0, 7'h72, 4'h0);
    rd(1'h1, 7'h17, 4'hf);
    $display("test reset done");
    acc(1'h0, 1'h1, 7'h72, 4'h5);
    rd(1'h0, 7'h72, 4'h5);
    acc(1'h0, 1'h1, 7'h73, 4'h3);
    rd(1'h0, 7'h73, 4'h3);
    chk({c_oe, d_oe}, 8'hac);
    chk({c_o, d_o}, 8'h00);
    @(posedge sys_clk);
    bank <= 1'h1;
    acc(1'h0, 1'h1, 7'h72, 4'hf);
    rd(1'h0, 7'h72, 4'h5);
    @(posedge sys_clk);
    bank <= 1'h0;
    press_a <= 4'h2;
    press_b <= 4'h8;
    acc(1'h0, 1'h1, 7'h70, 4'h0);
    rd(1'h0, 7'h70, 4'hd);
    rd(1'h0, 7'h71, 4'h7);
    $display("test ports done");
    @(posedge sys_clk);
    press_a <= 4'h0;
    press_b <= 4'h0;
    standby <= 1'h1;
    repeat (4) @(posedge sys_clk);
    press_b <= 4'h1;
    #1;
    chk(standby_release, 1'h0);
    chk({c_oe, d_oe}, 8'hff);
    repeat (3) @(posedge sys_clk);
    #1;
    chk(standby_release, 1'h1);
    standby <= 1'h0;
    press_b <= 4'h0;
    $display("test standby done");
    acc(1'h0, 1'h1, 7'h6f, 4'ha);
    chk(b_oe, 4'h0);
    ext_en <= 4'hc;
    ext_val <= 4'h4;
    acc(1'h1, 1'h1, 7'h27, 4'h3);
    chk({b_oe, b_o}, 8'h3a);
    chk(pull_on, 4'hf);
    rd(1'h0, 7'h6f, 4'h6);
    rd(1'h1, 7'h27, 4'h3);
    acc(1'h1, 1'h1, 7'h17, 4'h5);
    chk(pull_on, 4'h5);
    $display("test bit io done");
    int_lvl <= 1'h1;
    repeat (4) @(posedge sys_clk);
    rd(1'h1, 7'h0f, 4'h1);
    rd(1'h1, 7'h3e, 4'h1);
    acc(1'h1, 1'h1, 7'h3e, 4'h0);
    acc(1'h1, 1'h1, 7'h0f, 4'h0);
    rd(1'h1, 7'h3e, 4'h0);
    rd(1'h1, 7'h0f, 4'h1);
    int_lvl <= 1'h0;
    repeat (4) @(posedge sys_clk);
    rd(1'h1, 7'h3e, 4'h0);
    rd(1'h1, 7'h0f, 4'h0);
    acc(1'h1, 1'h1, 7'h1f, 4'h1);
    rd(1'h1, 7'h1f, 4'h1);
    int_lvl <= 1'h1;
    repeat (4) @(posedge sys_clk);
    rd(1'h1, 7'h3e, 4'h0);
    int_lvl <= 1'h0;
    repeat (4) @(posedge sys_clk);
    rd(1'h1, 7'h3e, 4'h1);
    $display("test interrupt done");
    acc(1'h1, 1'h1, 7'h00, 4'hf);
    rd(1'h1, 7'h00, 4'h0);
    rd(1'h1, 7'h72, 4'h5);
    chk(rf_mem_hit, 1'h0);
    acc(1'h1, 1'h0, 7'h55, 4'h0);
    chk(rf_mem_hit, 1'h1);
    $display("test file map done");
    wrap_up();
  end

  initial
  begin
    repeat (3000) @(posedge sys_clk);
    num_errors++;
    wrap_up();
  end
endmodule // test_keypad_ports_and_control_file

`default_nettype wire
